// file: src/rsx_exec.sv
// Executor for rotate, nibble swap, exclusive OR and direction load.
// Assumes one instruction per cycle from the core sequencer, inputs
// synchronous to core_clk_i, and the file register array held here.
`timescale 1ns/1ps

// Overview of operation
// - Rotate right file register; only carry changes
// - Destination 0 to accumulator, 1 to file
// - Swap nibbles of file register; flags untouched
// - Direction load copies accumulator for operand 6 only; no flags change
// - File xor with accumulator; only zero changes
// - Literal xor into accumulator; only zero changes
module rsx_exec
    import rsx_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Instruction issue
    input wire logic instr_valid_i,
    input wire rsx_instr_t instr_i,
    // Preload port for accumulator and file registers
    input wire logic preload_valid_i,
    input wire logic preload_to_file_i,
    input wire logic [4:0] preload_addr_i,
    input wire logic [7:0] preload_data_i,
    // File register read-back
    input wire logic [4:0] read_addr_i,
    output logic [7:0] read_data_o,
    // Architectural state
    output logic [7:0] acc_o,
    output rsx_flags_t flags_o,
    output logic [7:0] direction_o,
    // Completion
    output logic done_o,
    output logic [7:0] result_o
);

    // ********************************************************
    // State
    // ********************************************************
    logic [7:0] file_q [RSX_FILE_DEPTH]; // File register array
    logic [7:0] file_d [RSX_FILE_DEPTH];
    logic [7:0] acc_q; // Working register
    logic [7:0] acc_d;
    rsx_flags_t flags_q; // Carry and zero
    rsx_flags_t flags_d;
    logic [7:0] dir_q; // Port direction register
    logic [7:0] dir_d;
    logic done_q; // One-cycle completion pulse
    logic done_d;
    logic [7:0] result_q; // Last computed value
    logic [7:0] result_d;
    logic [7:0] read_q; // Registered read-back
    logic [7:0] read_d;

    // ********************************************************
    // Operand fetch and operation unit
    // ********************************************************
    logic [7:0] file_src; // Addressed file register
    rsx_alu_out_t alu_res; // Operation result

    assign file_src = file_q[instr_i.addr];

    rsx_alu u_alu (
        .instr_i(instr_i),
        .acc_i(acc_q),
        .file_i(file_src),
        .flags_i(flags_q),
        .res_o(alu_res)
    );

    // ********************************************************
    // Next-state logic
    // ********************************************************
    // An instruction outranks a preload in the same cycle, so the
    // sequencer never sees its own write lost behind a test load.
    always_comb begin
        file_d = file_q;
        acc_d = acc_q;
        flags_d = flags_q;
        dir_d = dir_q;
        done_d = 1'h0;
        result_d = result_q;
        read_d = file_q[read_addr_i];
        if (instr_valid_i) begin
            done_d = 1'h1;
            result_d = alu_res.value;
            // Flags change only where the operation owns them
            if (alu_res.upd_carry) begin
                flags_d.carry = alu_res.flags.carry;
            end
            if (alu_res.upd_zero) begin
                flags_d.zero = alu_res.flags.zero;
            end
            if (alu_res.write_dir) begin
                dir_d = alu_res.value;
            end
            if (alu_res.write_dest) begin
                // Literal form always lands in the accumulator
                if (instr_i.op == RSX_OP_XOR_LITERAL_WITH_ACC) begin
                    acc_d = alu_res.value;
                end else if (instr_i.dest == RSX_DEST_FILE) begin
                    file_d[instr_i.addr] = alu_res.value;
                end else begin
                    acc_d = alu_res.value;
                end
            end
        end else if (preload_valid_i) begin
            // Preload touches no flags
            if (preload_to_file_i) begin
                file_d[preload_addr_i] = preload_data_i;
            end else begin
                acc_d = preload_data_i;
            end
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************
    // Reset gives constants only; array cleared by a loop
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < RSX_FILE_DEPTH; i++) begin
                file_q[i] <= RSX_FILE_RESET;
            end
            acc_q <= RSX_ACC_RESET;
            flags_q <= '{carry: RSX_CARRY_RESET, zero: RSX_ZERO_RESET};
            dir_q <= RSX_DIR_RESET;
            done_q <= 1'h0;
            result_q <= 8'h00;
            read_q <= 8'h00;
        end else begin
            file_q <= file_d;
            acc_q <= acc_d;
            flags_q <= flags_d;
            dir_q <= dir_d;
            done_q <= done_d;
            result_q <= result_d;
            read_q <= read_d;
        end
    end

    // ********************************************************
    // Outputs, all straight from flip-flops
    // ********************************************************
    assign acc_o = acc_q;
    assign flags_o = flags_q;
    assign direction_o = dir_q;
    assign done_o = done_q;
    assign result_o = result_q;
    assign read_data_o = read_q;

endmodule

// file: inc/rsx_pkg.sv
// Shared types and constants for the rotate/swap/xor/direction executor.
// Assumes a single core clock and an active-low asynchronous reset.
package rsx_pkg;

    // ********************************************************
    // Widths and sizes
    // ********************************************************
    localparam int unsigned RSX_DATA_W = 8;
    localparam int unsigned RSX_ADDR_W = 5;
    localparam int unsigned RSX_FILE_DEPTH = 32;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int unsigned RSX_MSB = 7;
    localparam int unsigned RSX_LSB = 0;
    localparam int unsigned RSX_HI_NIB_LO = 4;
    localparam int unsigned RSX_LO_NIB_HI = 3;

    // ********************************************************
    // Operand and destination codes
    // ********************************************************
    localparam logic [4:0] RSX_DIR_OPERAND = 5'h06;
    localparam logic RSX_DEST_ACC = 1'h0;
    localparam logic RSX_DEST_FILE = 1'h1;

    // ********************************************************
    // Values after reset
    // ********************************************************
    localparam logic [7:0] RSX_ACC_RESET = 8'h00;
    localparam logic [7:0] RSX_FILE_RESET = 8'h00;
    localparam logic [7:0] RSX_DIR_RESET = 8'hFF;
    localparam logic RSX_CARRY_RESET = 1'h0;
    localparam logic RSX_ZERO_RESET = 1'h0;

    // ********************************************************
    // Types
    // ********************************************************
    // Instruction selector
    typedef enum logic [2:0] {
        RSX_OP_ROTATE_RIGHT_VIA_CARRY = 3'h0,
        RSX_OP_NIBBLE_EXCHANGE = 3'h1,
        RSX_OP_XOR_FILE_WITH_ACC = 3'h2,
        RSX_OP_XOR_LITERAL_WITH_ACC = 3'h3,
        RSX_OP_DIRECTION_LOAD = 3'h4
    } rsx_op_t;

    // One instruction as issued by the sequencer
    typedef struct packed {
        rsx_op_t op;
        logic [4:0] addr;
        logic dest;
        logic [7:0] literal;
    } rsx_instr_t;

    // Status flags touched by this block
    typedef struct packed {
        logic carry;
        logic zero;
    } rsx_flags_t;

    // Result of the operation unit
    typedef struct packed {
        logic [7:0] value;
        rsx_flags_t flags;
        logic upd_carry;
        logic upd_zero;
        logic write_dest;
        logic write_dir;
    } rsx_alu_out_t;

endpackage

// file: src/rsx_alu.sv
// Combinational operation unit for the rotate/swap/xor/direction executor.
// Assumes operands are already fetched; holds no state.
`timescale 1ns/1ps

module rsx_alu
    import rsx_pkg::*;
(
    // Instruction and operands
    input wire rsx_instr_t instr_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] file_i,
    input wire rsx_flags_t flags_i,
    // Result
    output rsx_alu_out_t res_o
);

    // ********************************************************
    // Helpers
    // ********************************************************
    // Zero test shared by both exclusive-OR forms
    function automatic logic rsx_is_zero(input logic [7:0] v);
        rsx_is_zero = (v == 8'h00);
    endfunction

    // ********************************************************
    // Operation decode
    // ********************************************************
    // Flags pass through unless an operation owns them
    always_comb begin
        res_o = '0;
        res_o.flags = flags_i;
        unique case (instr_i.op)
            RSX_OP_ROTATE_RIGHT_VIA_CARRY: begin
                // Old carry into the top, bottom bit out to carry
                res_o.value = {flags_i.carry, file_i[RSX_MSB:1]};
                res_o.flags.carry = file_i[RSX_LSB];
                res_o.upd_carry = 1'h1;
                res_o.write_dest = 1'h1;
            end
            RSX_OP_NIBBLE_EXCHANGE: begin
                // No flag changes at all
                res_o.value = {file_i[RSX_LO_NIB_HI:RSX_LSB],
                               file_i[RSX_MSB:RSX_HI_NIB_LO]};
                res_o.write_dest = 1'h1;
            end
            RSX_OP_XOR_FILE_WITH_ACC: begin
                res_o.value = acc_i ^ file_i;
                res_o.flags.zero = rsx_is_zero(acc_i ^ file_i);
                res_o.upd_zero = 1'h1;
                res_o.write_dest = 1'h1;
            end
            RSX_OP_XOR_LITERAL_WITH_ACC: begin
                res_o.value = acc_i ^ instr_i.literal;
                res_o.flags.zero =
                    rsx_is_zero(acc_i ^ instr_i.literal);
                res_o.upd_zero = 1'h1;
                res_o.write_dest = 1'h1;
            end
            RSX_OP_DIRECTION_LOAD: begin
                // Only the one legal operand reaches the register
                res_o.value = acc_i;
                res_o.write_dir =
                    (instr_i.addr == RSX_DIR_OPERAND);
            end
            default: begin
                // Illegal code: nothing is written
                res_o.value = 8'h00;
            end
        endcase
    end

endmodule

// file: test/rsx_exec_monitor.sv
// Port checker for the rotate/swap/xor/direction executor.
// Assumes one core clock and the active-low reset of rsx_exec.
`timescale 1ns/1ps

module rsx_exec_monitor
    import rsx_pkg::*;
(
    // Clock, reset and issue
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic instr_valid_i,
    input wire rsx_instr_t instr_i,
    // Observed state
    input wire logic [7:0] acc_o,
    input wire rsx_flags_t flags_o,
    input wire logic [7:0] direction_o,
    input wire logic done_o,
    input wire logic [7:0] result_o
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Opcode taken this edge; 7 stands for no issue
    rsx_op_t op;
    assign op = instr_valid_i ? instr_i.op : rsx_op_t'(3'h7);

    AST_DONE_PULSE:
        assert property (instr_valid_i |=> done_o)
        else $error("no completion after issue");
    AST_ROT_ZERO_KEPT:
        assert property (op == RSX_OP_ROTATE_RIGHT_VIA_CARRY |=>
            $stable(flags_o.zero)) else $error("rotate changed zero");
    AST_ROT_CARRY_IN:
        assert property (op == RSX_OP_ROTATE_RIGHT_VIA_CARRY |=>
            result_o[7] == $past(flags_o.carry)) else $error("rotate msb");
    AST_DEST_ACC:
        assert property (op < RSX_OP_XOR_LITERAL_WITH_ACC && !instr_i.dest
            |=> acc_o == result_o) else $error("acc not written");
    AST_DEST_FILE:
        assert property (op < RSX_OP_XOR_LITERAL_WITH_ACC && instr_i.dest
            |=> $stable(acc_o)) else $error("acc written for file dest");
    AST_SWAP_FLAGS:
        assert property (op == RSX_OP_NIBBLE_EXCHANGE |=> $stable(flags_o))
        else $error("swap changed flags");
    AST_DIR_LOAD:
        assert property (op == RSX_OP_DIRECTION_LOAD && instr_i.addr ==
            RSX_DIR_OPERAND |=> direction_o == $past(acc_o) &&
            $stable(flags_o)) else $error("direction load wrong");
    AST_XORF_ZERO:
        assert property (op == RSX_OP_XOR_FILE_WITH_ACC |=> $stable(
            flags_o.carry) && flags_o.zero == (result_o == 8'h00))
        else $error("file xor flags wrong");
    AST_XORL_ACC:
        assert property (op == RSX_OP_XOR_LITERAL_WITH_ACC |=> acc_o ==
            ($past(acc_o) ^ $past(instr_i.literal)) && flags_o.zero ==
            (acc_o == 8'h00)) else $error("literal xor wrong");
endmodule

bind rsx_exec rsx_exec_monitor mon_u (.core_clk_i, .reset_n_i,
    .instr_valid_i, .instr_i, .acc_o, .flags_o, .direction_o, .done_o,
    .result_o);

// file: test/rsx_exec_tb.sv
// Self-checking bench for the rotate/swap/xor/direction executor.
// Drives all ports of rsx_exec and keeps a reference model.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module rsx_exec_tb
    import rsx_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic instr_valid_i = 1'b0;
    rsx_instr_t instr_i = '0;
    logic preload_valid_i = 1'b0;
    logic preload_to_file_i = 1'b0;
    logic [4:0] preload_addr_i = 5'h00;
    logic [7:0] preload_data_i = 8'h00;
    logic [4:0] read_addr_i = 5'h00;
    logic [7:0] read_data_o, acc_o, direction_o, result_o;
    rsx_flags_t flags_o;
    logic done_o;
    // Reference model and pending notes
    logic [7:0] m_acc, m_dir, m_file [32];
    logic m_c, m_z;
    logic [33:0] notes [$];
    logic [33:0] exp_note, got_note;
    rsx_instr_t ri;
    int err_count = 0;
    int tests_run = 0;

    always #5 core_clk_i = ~core_clk_i;
    assign got_note = {result_o, acc_o, flags_o, direction_o, read_data_o};

    rsx_exec dut_u (.core_clk_i, .reset_n_i, .instr_valid_i, .instr_i,
        .preload_valid_i, .preload_to_file_i, .preload_addr_i,
        .preload_data_i, .read_addr_i, .read_data_o, .acc_o, .flags_o,
        .direction_o, .done_o, .result_o);

    task automatic final_report();
        $display("errors=%0d checks=%0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic model_reset();
        m_acc = RSX_ACC_RESET;
        m_dir = RSX_DIR_RESET;
        m_c = RSX_CARRY_RESET;
        m_z = RSX_ZERO_RESET;
        foreach (m_file[i]) m_file[i] = RSX_FILE_RESET;
    endtask

    // One cycle of stimulus; read port follows the instruction address
    task automatic step(input rsx_instr_t ins, input logic v, pv, pf,
                        input logic [4:0] pa, input logic [7:0] pd);
        logic [7:0] f, r;
        @(negedge core_clk_i);
        {instr_valid_i, instr_i, read_addr_i} = {v, ins, ins.addr};
        {preload_valid_i, preload_to_file_i} = {pv, pf};
        {preload_addr_i, preload_data_i} = {pa, pd};
        f = m_file[ins.addr];
        r = 8'h00;
        if (v) begin
            case (ins.op)
                RSX_OP_ROTATE_RIGHT_VIA_CARRY: begin
                    r = {m_c, f[7:1]};
                    m_c = f[0];
                end
                RSX_OP_NIBBLE_EXCHANGE: r = {f[3:0], f[7:4]};
                RSX_OP_XOR_FILE_WITH_ACC: r = m_acc ^ f;
                RSX_OP_XOR_LITERAL_WITH_ACC: r = m_acc ^ ins.literal;
                RSX_OP_DIRECTION_LOAD: r = m_acc;
                default: r = 8'h00;
            endcase
            if (ins.op == RSX_OP_DIRECTION_LOAD && ins.addr == 5'h06)
                m_dir = m_acc;
            if (ins.op inside {RSX_OP_XOR_FILE_WITH_ACC,
                RSX_OP_XOR_LITERAL_WITH_ACC}) m_z = (r == 8'h00);
            if (ins.op < RSX_OP_XOR_LITERAL_WITH_ACC && ins.dest)
                m_file[ins.addr] = r;
            else if (ins.op <= RSX_OP_XOR_LITERAL_WITH_ACC) m_acc = r;
            notes.push_back({r, m_acc, m_c, m_z, m_dir, f});
        end else if (pv) begin
            if (pf) m_file[pa] = pd;
            else m_acc = pd;
        end
    endtask

    // Random traffic; direction loads aim at operand 6 or 7
    task automatic burst(input int n);
        repeat (n) begin
            ri = rsx_instr_t'(16'($urandom));
            if (ri.op == RSX_OP_DIRECTION_LOAD) ri.addr = {4'h3, ri.addr[0]};
            step(ri, $urandom_range(0, 3) != 0, 1'($urandom),
                 1'($urandom), 5'($urandom), 8'($urandom));
        end
        repeat (2) step('0, 1'b0, 1'b0, 1'b0, 5'h00, 8'h00);
    endtask

    // Watcher pairs every completion with the oldest note
    always @(negedge core_clk_i) begin
        if (done_o === 1'b1) begin
            exp_note = (notes.size() > 0) ? notes.pop_front() : 'x;
            `CHK(got_note,exp_note)
        end
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        void'($urandom(32'h3FDA));
        model_reset();
        repeat (20) @(posedge core_clk_i);
        @(negedge core_clk_i);
        reset_n_i = 1'b1;
        `CHK({acc_o, flags_o, direction_o}, {8'h00, 2'h0, 8'hFF})
        // Back-to-back rotates carry the old bit round
        step('0, 1'b0, 1'b1, 1'b1, 5'h03, 8'h81);
        repeat (2) step('{RSX_OP_ROTATE_RIGHT_VIA_CARRY, 5'h03, 1'b1, 8'h00},
                        1'b1, 1'b0, 1'b0, 5'h00, 8'h00);
        // Literal equal to acc must raise zero
        step('0, 1'b0, 1'b1, 1'b0, 5'h00, 8'h5A);
        step('{RSX_OP_XOR_LITERAL_WITH_ACC, 5'h00, 1'b0, 8'h5A},
             1'b1, 1'b0, 1'b0, 5'h00, 8'h00);
        // Every opcode, each with a preload that must be dropped
        for (int k = 0; k < 8; k++) begin
            step('{rsx_op_t'(k), 5'h06, k[0], 8'hA0}, 1'b1, 1'b1, 1'b0,
                 5'h00, 8'h33);
        end
        burst(3000);
        // Reset in mid-run, then more traffic
        @(negedge core_clk_i);
        reset_n_i = 1'b0;
        model_reset();
        repeat (2) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        burst(300);
        `CHK(notes.size(), 0)
        final_report();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk_i);
        err_count++;
        final_report();
    end
endmodule
